// [src/dsm_pkg.sv]
// Package for the dual style microprocessor port.
// Holds the access timing table, port widths and the sequencer states.
// Assumes a 50 MHz master clock; all latencies are in master clock cycles.
package dsm_pkg;

	// ----------------------------------------------------------------
	// Widths and clock
	// ----------------------------------------------------------------
	localparam int DSM_CLK_PERIOD_NS = 20;
	localparam int DSM_ADDR_W = 3;
	localparam int DSM_DATA_W = 8;
	localparam int DSM_CNT_W = 4;

	// ----------------------------------------------------------------
	// Access latency limits, counted from the strobe falling edge
	// ----------------------------------------------------------------
	localparam logic [3:0] DSM_WR_LAT_MIN = 4'h4;
	localparam logic [3:0] DSM_WR_LAT_MAX = 4'h9;
	localparam logic [3:0] DSM_RD_LAT_MIN = 4'h8;
	localparam logic [3:0] DSM_RD_LAT_MAX = 4'hD;
	localparam logic [3:0] DSM_LAT_BIAS = 4'h2;

	// Mode pin levels.
	localparam logic DSM_MODE_SPLIT = 1'b0;
	localparam logic DSM_MODE_COMBINED = 1'b1;

	// Access sequencer states.
	typedef enum logic [1:0] {
		DSM_IDLE,
		DSM_WAIT,
		DSM_DONE
	} dsm_state_t;

	// Write latency for an address: grows with the address, capped at the maximum.
	function automatic logic [3:0] dsm_wr_latency(input logic [2:0] addr);
		logic [3:0] lat;
		lat = DSM_WR_LAT_MIN + {1'b0, addr};
		return (lat > DSM_WR_LAT_MAX) ? DSM_WR_LAT_MAX : lat;
	endfunction : dsm_wr_latency

	// Read latency for an address: grows with the address, capped at the maximum.
	function automatic logic [3:0] dsm_rd_latency(input logic [2:0] addr);
		logic [3:0] lat;
		lat = DSM_RD_LAT_MIN + {1'b0, addr};
		return (lat > DSM_RD_LAT_MAX) ? DSM_RD_LAT_MAX : lat;
	endfunction : dsm_rd_latency

endpackage : dsm_pkg

// [src/dsm_timer_if.sv]
// Interface between the port sequencer and its latency timer.
// Assumes both ends run on the same master clock.
`timescale 1ns/100ps
`default_nettype none

interface dsm_timer_if;
	logic start;
	logic [3:0] load;
	logic expired;

	modport ctrl (output start, output load, input expired);
	modport timer (input start, input load, output expired);
endinterface : dsm_timer_if

`default_nettype wire

// [src/dsm_timer.sv]
// Access latency timer for the microprocessor port.
// Assumes the sequencer only looks at expired while it waits on an access.
`timescale 1ns/100ps
`default_nettype none

module dsm_timer (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	dsm_timer_if.timer tmr
);

	typedef struct packed {
		logic [3:0] cnt;
	} dsm_timer_regs_t;

	dsm_timer_regs_t r_q;
	dsm_timer_regs_t r_d;

	// ----------------------------------------------------------------
	// Countdown
	// ----------------------------------------------------------------

	// Load leaves two cycles for the start edge and the completion edge.
	always_comb begin
		r_d = r_q;
		if (tmr.start) begin
			r_d.cnt = tmr.load - dsm_pkg::DSM_LAT_BIAS;
		end else if (r_q.cnt != 4'h0) begin
			r_d.cnt = r_q.cnt - 4'h1;
		end
	end

	// State register.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	// Expiry flags the last waiting cycle.
	assign tmr.expired = (r_q.cnt == 4'h0);

	a_timer_counts_down: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(tmr.start && tmr.load == 4'h4) |=> (r_q.cnt == 4'h2) ##2 tmr.expired)
		else $error("Timer did not run down a four cycle load.");

endmodule : dsm_timer

`default_nettype wire

// [src/dsm_microport.sv]
// Dual style microprocessor port: 8-bit data, 3-bit address, strobe handshake.
// Assumes all pins are synchronous to sys_clk_in and the ready pin is pulled up outside.
`timescale 1ns/100ps
`default_nettype none

module dsm_microport (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic mode_in,
	input wire logic cs_low_in,
	input wire logic data_strobe_low_in,
	input wire logic rw_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_out,
	output logic transfer_ack_low_out,
	output logic transfer_ack_low_oe_out,
	output logic [2:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out,
	input wire logic [7:0] reg_rdata_in
);

	typedef struct packed {
		dsm_pkg::dsm_state_t st;
		logic mode;
		logic rd;
		logic cap;
		logic ack_oe;
		logic data_oe;
		logic [7:0] rdata;
		logic ext_wr;
		logic ext_rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} dsm_regs_t;

	dsm_regs_t r_q;
	dsm_regs_t r_d;
	dsm_timer_if tmr ();

	logic combined;
	logic req_act;
	logic req_rd;
	logic rd_act;
	logic next_mode;

	// ----------------------------------------------------------------
	// Strobe decode
	// ----------------------------------------------------------------

	// Combined style qualifies the strobe alone; split style takes either strobe.
	always_comb begin
		combined = (mode_in == dsm_pkg::DSM_MODE_COMBINED);
		if (combined) begin
			req_act = !cs_low_in && !data_strobe_low_in;
			req_rd = rw_in;
		end else begin
			req_act = !cs_low_in && (!data_strobe_low_in || !rw_in);
			req_rd = !data_strobe_low_in;
		end
		rd_act = !cs_low_in && !data_strobe_low_in && req_rd;
	end

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------

	// Start on the first sampled strobe, wait out the address latency, hold the answer until release.
	always_comb begin
		r_d = r_q;
		r_d.ext_wr = 1'b0;
		r_d.ext_rd = 1'b0;
		r_d.cap = r_q.ext_rd;
		tmr.start = 1'b0;
		tmr.load = r_q.rd ? dsm_pkg::dsm_rd_latency(r_q.addr) : dsm_pkg::dsm_wr_latency(r_q.addr);
		unique case (r_q.st)
			dsm_pkg::DSM_IDLE: begin
				if (req_act) begin
					r_d.st = dsm_pkg::DSM_WAIT;
					r_d.mode = combined;
					r_d.rd = req_rd;
					r_d.addr = addr_in;
					r_d.wdata = data_in;
					r_d.ext_wr = !req_rd;
					r_d.ext_rd = req_rd;
					tmr.start = 1'b1;
					tmr.load = req_rd ? dsm_pkg::dsm_rd_latency(addr_in) : dsm_pkg::dsm_wr_latency(addr_in);
				end
			end
			dsm_pkg::DSM_WAIT: begin
				if (tmr.expired) begin
					r_d.st = dsm_pkg::DSM_DONE;
				end
			end
			dsm_pkg::DSM_DONE: begin
				if (!req_act) begin
					r_d.st = dsm_pkg::DSM_IDLE;
				end
			end
		endcase
		// Captured read data appears two cycles after the register side is asked.
		if (r_q.cap) begin
			r_d.rdata = reg_rdata_in;
		end
		// Split style pulls ready low while busy; combined style pulls acknowledge low when done.
		next_mode = r_d.mode;
		r_d.ack_oe = next_mode ? (r_d.st == dsm_pkg::DSM_DONE) : (r_d.st == dsm_pkg::DSM_WAIT);
		r_d.data_oe = rd_act;
	end

	// State register.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			r_q <= '{st: dsm_pkg::DSM_IDLE, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	dsm_timer u_timer (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.tmr(tmr)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Every output but the tied-low acknowledge level comes from the state register; the acknowledge pin only ever pulls low.
	assign data_out = r_q.rdata;
	assign data_oe_out = r_q.data_oe;
	assign transfer_ack_low_out = 1'b0;
	assign transfer_ack_low_oe_out = r_q.ack_oe;
	assign reg_addr_out = r_q.addr;
	assign reg_wdata_out = r_q.wdata;
	assign reg_wr_out = r_q.ext_wr;
	assign reg_rd_out = r_q.ext_rd;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	a_split_wr_bound: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_IDLE && req_act && !req_rd && !combined)
		|=> r_q.ack_oe ##[2:8] !r_q.ack_oe)
		else $error("Split write ready did not rise within nine clocks.");

	a_read_ack_bound: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_IDLE && req_act && req_rd)
		|-> ##[7:13] (r_q.st == dsm_pkg::DSM_DONE))
		else $error("Read was not acknowledged within thirteen clocks.");

	a_comb_wr_ack: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_IDLE && req_act && !req_rd && combined)
		|=> !r_q.ack_oe ##[2:8] r_q.ack_oe)
		else $error("Combined write acknowledge did not fall within nine clocks.");

	a_addr_zero_lat: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_IDLE && req_act && !req_rd && addr_in == 3'h0)
		|-> ##3 (r_q.st == dsm_pkg::DSM_WAIT) ##1 (r_q.st == dsm_pkg::DSM_DONE))
		else $error("Write to address zero did not finish in four clocks.");

	a_cs_gates_start: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_IDLE && cs_low_in) |=> (r_q.st == dsm_pkg::DSM_IDLE))
		else $error("Access started without chip select.");

	a_comb_strobe_start: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_IDLE && combined && !cs_low_in && !data_strobe_low_in)
		|=> (r_q.st == dsm_pkg::DSM_WAIT) && r_q.mode && (r_q.rd == $past(rw_in)))
		else $error("Data strobe did not start a combined access.");

	a_ack_idle_free: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_IDLE) |-> !r_q.ack_oe)
		else $error("Acknowledge pin driven while the port is idle.");

	a_ext_wr_pulse: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_IDLE && req_act && !req_rd)
		|=> reg_wr_out && (reg_addr_out == $past(addr_in)) ##1 !reg_wr_out)
		else $error("Register write strobe was not a single pulse at the sampled address.");

	a_bus_read_only: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		data_oe_out |-> $past(rd_act))
		else $error("Data bus driven outside a selected read.");

	// ----------------------------------------------------------------
	// Completion and hand-off checks
	// ----------------------------------------------------------------

	// A combined acknowledge must stand for as long as the host holds the access.
	a_comb_ack_holds: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_DONE && r_q.mode && req_act) |=> r_q.ack_oe)
		else $error("Combined acknowledge let go while the access was still held.");

	// Releasing the access frees the pin and returns the port to idle in one edge.
	a_ack_release_idle: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_DONE && !req_act) |=> (!r_q.ack_oe && r_q.st == dsm_pkg::DSM_IDLE))
		else $error("Port did not free the pin and go idle after release.");

	// Split style keeps ready pulled low for the whole wait.
	a_split_busy_low: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		(r_q.st == dsm_pkg::DSM_WAIT && !r_q.mode) |-> r_q.ack_oe)
		else $error("Split style ready was high while the access was waiting.");

	// Read data on the bus is what the register side offered at the capture edge.
	a_read_capture: assert property (@(posedge sys_clk_in) disable iff (reset_in)
		r_q.cap |=> (data_out == $past(reg_rdata_in)))
		else $error("Read data was not captured from the register side.");

endmodule : dsm_microport

`default_nettype wire

// [tb/dsm_host_model.sv]
// Host processor model for the dual style port: runs one access and waits for the answer.
// Assumes the ready pin is pulled up and that the bench calls one task at a time.
`timescale 1ns/100ps
`default_nettype none

module dsm_host_model (
	input wire logic clk_in,
	input wire logic ack_oe_in,
	input wire logic bus_oe_in,
	input wire logic [7:0] bus_in,
	output logic mode_out,
	output logic cs_low_out,
	output logic strobe_low_out,
	output logic rw_out,
	output logic [2:0] addr_out,
	output logic [7:0] data_out
);
	logic ack_pin;

	// The pin idles high through the pull-up while nobody pulls it low.
	assign ack_pin = ack_oe_in ? 1'b0 : 1'b1;

	// All pins start released.
	initial begin
		{mode_out, cs_low_out, strobe_low_out, rw_out} = 4'hF;
		addr_out = 3'h0;
		data_out = 8'h00;
	end

	// One access; the latency is counted since nothing fixed can be assumed.
	task automatic xfer(input logic md, input logic rd, input logic [2:0] a, input logic [7:0] d,
		output int n, output logic [7:0] q, output logic oe);
		logic seen;
		seen = 1'b0;
		oe = 1'b0;
		n = 0;
		@(negedge clk_in);
		mode_out = md;
		addr_out = a;
		data_out = d;
		rw_out = rd;
		// Combined style always lowers the data strobe; split style lowers it only to read.
		strobe_low_out = ~md & ~rd;
		cs_low_out = 1'b0;
		while (n < 20 && !(md ? !ack_pin : (seen && ack_pin))) begin
			seen = seen | !ack_pin;
			@(negedge clk_in);
			oe = oe | bus_oe_in;
			n++;
		end
		q = bus_oe_in ? bus_in : ~bus_in;
		{cs_low_out, strobe_low_out, rw_out} = 3'h7;
		data_out = ~d;
	endtask : xfer

	// Strobes moved with chip select high; counts cycles with any answer.
	task automatic stray(input int cyc, output int busy);
		busy = 0;
		@(negedge clk_in);
		{strobe_low_out, rw_out} = 2'h0;
		repeat (cyc) begin
			@(negedge clk_in);
			busy += int'(!ack_pin || bus_oe_in);
		end
		{strobe_low_out, rw_out} = 2'h3;
	endtask : stray
endmodule : dsm_host_model

`default_nettype wire

// [tb/dsm_microport_tb_top.sv]
// Self-checking bench for the dual style port.
// Assumes the register side answers with data derived from the address.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end

module dsm_microport_tb_top;
	logic sys_clk, reset, mode, cs_low, strobe_low, rw, data_oe, ack, ack_oe, reg_wr, reg_rd;
	logic [2:0] addr, reg_addr, wr_a;
	logic [7:0] wdata, rdata, reg_wdata, reg_rdata, wr_d;
	int miscompares = 0;
	int num_checks = 0;
	int wr_cnt = 0;
	int rd_cnt = 0;

	// Register side answers with a pattern tied to the address.
	assign reg_rdata = {reg_addr, ~reg_addr, 2'h2};

	dsm_microport uut (.sys_clk_in(sys_clk), .reset_in(reset), .mode_in(mode), .cs_low_in(cs_low),
		.data_strobe_low_in(strobe_low), .rw_in(rw), .addr_in(addr), .data_in(wdata), .data_out(rdata),
		.data_oe_out(data_oe), .transfer_ack_low_out(ack), .transfer_ack_low_oe_out(ack_oe),
		.reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
		.reg_rdata_in(reg_rdata));

	dsm_host_model host (.clk_in(sys_clk), .ack_oe_in(ack_oe), .bus_oe_in(data_oe), .bus_in(rdata),
		.mode_out(mode), .cs_low_out(cs_low), .strobe_low_out(strobe_low), .rw_out(rw),
		.addr_out(addr), .data_out(wdata));

	// Clock at 50 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Register side pulses are counted and the write payload kept.
	always @(posedge sys_clk) begin
		if (reg_wr) begin
			wr_cnt++;
			wr_a = reg_addr;
			wr_d = reg_wdata;
		end
		if (reg_rd) rd_cnt++;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	// Every address written in both styles.
	task automatic t_writes();
		int n, c;
		logic [7:0] q, d;
		logic oe;
		for (int md = 0; md < 2; md++) begin
			for (int a = 0; a < 8; a++) begin
				d = {~a[2:0], md[0], 1'b1, a[2:0]};
				c = wr_cnt;
				host.xfer(md[0], 1'b0, a[2:0], d, n, q, oe);
				`CHK("write latency", (a > 5) ? 9 : 4 + a, n)
				`CHK("write pulses", 1, wr_cnt - c)
				`CHK("write address", a[2:0], wr_a)
				`CHK("write data", d, wr_d)
				`CHK("bus driven on write", 1'b0, oe)
			end
		end
		$display("test writes done");
	endtask : t_writes

	// Every address read in both styles.
	task automatic t_reads();
		int n, c;
		logic [7:0] q;
		logic oe;
		for (int md = 0; md < 2; md++) begin
			for (int a = 0; a < 8; a++) begin
				c = rd_cnt;
				host.xfer(md[0], 1'b1, a[2:0], 8'h5A, n, q, oe);
				`CHK("read latency", (a > 5) ? 13 : 8 + a, n)
				`CHK("read pulses", 1, rd_cnt - c)
				`CHK("read data", {a[2:0], ~a[2:0], 2'h2}, q)
				`CHK("bus driven on read", 1'b1, oe)
				@(negedge sys_clk);
				`CHK("bus released", 1'b0, data_oe)
				`CHK("ready after release", 1'b0, ack_oe)
			end
		end
		$display("test reads done");
	endtask : t_reads

	// Strobes without chip select are ignored.
	task automatic t_nocs();
		int busy, cw, cr;
		cw = wr_cnt;
		cr = rd_cnt;
		host.stray(12, busy);
		`CHK("answers without select", 0, busy)
		`CHK("pulses without select", 0, wr_cnt - cw + rd_cnt - cr)
		$display("test no select done");
	endtask : t_nocs

	// Reset, then the scenarios.
	initial begin
		reset = 1'b1;
		repeat (16) @(negedge sys_clk);
		reset = 1'b0;
		`CHK("ack after reset", 1'b0, ack_oe)
		`CHK("ack pin pulls low only", 1'b0, ack)
		`CHK("bus after reset", 1'b0, data_oe)
		t_writes();
		t_reads();
		t_nocs();
		give_verdict();
	end

	// Watchdog well past the expected run length.
	initial begin
		#(4000 * 20);
		miscompares++;
		give_verdict();
	end
endmodule : dsm_microport_tb_top

`default_nettype wire
